//--- inc/fsh_pin_if.sv
// Purpose: carries one access request from the register front end to the pin engine
// Assumes: single clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
interface fsh_pin_if;
   logic start;
   logic wr;
   logic wide;
   logic [19:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic busy;
   logic done;
   modport master (output start, output wr, output wide, output addr, output wdata,
      input rdata, input busy, input done);
   modport engine (input start, input wr, input wide, input addr, input wdata,
      output rdata, output busy, output done);
endinterface

//--- inc/fsh_pkg.sv
// Purpose: constants shared by the flash status host controller
// Assumes: 20 MHz system clock, AHB-Lite register access
// Notes: device status layout and command codes, host register map
package fsh_pkg;
   // ---------------------------------------------------------------
   // host register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] FSH_REG_CTRL = 8'h00;
   localparam logic [7:0] FSH_REG_ADDR = 8'h04;
   localparam logic [7:0] FSH_REG_WDATA = 8'h08;
   localparam logic [7:0] FSH_REG_RDATA = 8'h0C;
   localparam logic [7:0] FSH_REG_STAT = 8'h10;
   // ctrl fields
   localparam int FSH_CTRL_GO = 0;
   localparam int FSH_CTRL_WRITE = 1;
   localparam int FSH_CTRL_WIDE = 2;
   localparam int FSH_CTRL_POLL = 3;
   localparam int FSH_CTRL_RST = 4;
   localparam int FSH_CTRL_WP = 5;
   // status fields
   localparam int FSH_STAT_BUSY = 0;
   localparam int FSH_STAT_READY = 1;
   localparam int FSH_STAT_VALID = 2;
   // ---------------------------------------------------------------
   // device status word
   // ---------------------------------------------------------------
   localparam int FSH_SEQ_READY_BIT = 7;
   localparam int FSH_ERASE_SUSP_BIT = 6;
   localparam int FSH_ERASE_FAIL_BIT = 5;
   localparam int FSH_PROG_FAIL_BIT = 4;
   localparam int FSH_SUPPLY_FAULT_BIT = 3;
   localparam int FSH_PROG_SUSP_BIT = 2;
   localparam logic [7:0] FSH_RESERVED_MASK = 8'hFC;
   // ---------------------------------------------------------------
   // commands
   // ---------------------------------------------------------------
   localparam logic [7:0] FSH_CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] FSH_CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] FSH_CMD_RESUME = 8'hD0;
   localparam logic [7:0] FSH_CMD_SUSPEND = 8'hB0;
   // ---------------------------------------------------------------
   // pin timing
   // ---------------------------------------------------------------
   localparam int FSH_CLK_MHZ = 20;
   localparam int FSH_ACCESS_NS = 100;
   localparam int FSH_ACCESS_CYC = (FSH_ACCESS_NS * FSH_CLK_MHZ + 999) / 1000;
   localparam int FSH_RECOVER_NS = 50;
   localparam int FSH_RECOVER_CYC = (FSH_RECOVER_NS * FSH_CLK_MHZ + 999) / 1000;
   localparam int FSH_ADDR_W = 20;
   localparam int FSH_DATA_W = 16;
endpackage

//--- src/fsh_host_ctrl.sv
// Purpose: AHB-Lite controlled host that drives a dual-bank flash through its pins
// Assumes: single 20 MHz clock, synchronous active-high reset
// Notes: software issues single pin cycles; status polls are masked and qualified here
`timescale 1ns/1ps
module fsh_host_ctrl
   import fsh_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe_out,
   output logic [19:0] addr_out,
   output logic ce_n_out,
   output logic oe_n_out,
   output logic we_n_out,
   output logic byte_n_out,
   output logic reset_powerdown_n_out,
   output logic write_protect_n_out
);
   fsh_pin_if pin ();

   // ---------------------------------------------------------------
   // bus front end
   // ---------------------------------------------------------------
   logic aw_q, aw_d;
   logic ar_q, ar_d;
   logic [7:0] aa_q, aa_d;
   logic [5:0] ctrl_q, ctrl_d;
   logic [19:0] addr_q, addr_d;
   logic [15:0] wdata_q, wdata_d;
   logic [15:0] rdata_q, rdata_d;
   logic ready_q, ready_d;
   logic valid_q, valid_d;
   logic start_q, start_d;
   logic [31:0] hrdata_q, hrdata_d;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_off);
      addr_hit = (a == reg_off);
   endfunction

   logic take;
   assign take = hsel_in && hready_in && htrans_in[1];

   // ---------------------------------------------------------------
   // register writes and pin cycle launch
   // ---------------------------------------------------------------
   always_comb begin
      aw_d = take && hwrite_in;
      ar_d = take && !hwrite_in;
      aa_d = take ? haddr_in[7:0] : aa_q;
      ctrl_d = ctrl_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      start_d = 1'b0;
      ctrl_d[FSH_CTRL_GO] = 1'b0;
      if (aw_q) begin
         if (addr_hit(aa_q, FSH_REG_CTRL)) begin
            ctrl_d = hwdata_in[5:0];
            // go is a strobe, never stored
            ctrl_d[FSH_CTRL_GO] = 1'b0;
            // no strobes while reset pin low
            // refused, not queued: a cycle on a device held in reset is lost anyway
            start_d = hwdata_in[FSH_CTRL_GO] && !hwdata_in[FSH_CTRL_RST] && !pin.busy && !start_q;
         end
         if (addr_hit(aa_q, FSH_REG_ADDR)) begin
            addr_d = hwdata_in[19:0];
         end
         if (addr_hit(aa_q, FSH_REG_WDATA)) begin
            wdata_d = hwdata_in[15:0];
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         aw_q <= 1'b0;
         ar_q <= 1'b0;
         aa_q <= 8'h00;
         ctrl_q <= 6'h04;
         addr_q <= 20'h00000;
         wdata_q <= 16'h0000;
         start_q <= 1'b0;
      end else begin
         aw_q <= aw_d;
         ar_q <= ar_d;
         aa_q <= aa_d;
         ctrl_q <= ctrl_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         start_q <= start_d;
      end
   end

   // ---------------------------------------------------------------
   // status capture
   // ---------------------------------------------------------------
   always_comb begin
      rdata_d = rdata_q;
      ready_d = ready_q;
      valid_d = valid_q;
      if (start_d) begin
         valid_d = 1'b0;
      end
      // a completion in the launch cycle still sets: it belongs to the older cycle
      if (pin.done) begin
         if (ctrl_q[FSH_CTRL_POLL]) begin
            rdata_d = {8'h00, pin.rdata[7:0] & FSH_RESERVED_MASK};
            ready_d = pin.rdata[FSH_SEQ_READY_BIT];
            valid_d = pin.rdata[FSH_SEQ_READY_BIT];
         end else begin
            rdata_d = pin.rdata;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         rdata_q <= 16'h0000;
         ready_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         valid_q <= valid_d;
      end
   end

   // ---------------------------------------------------------------
   // register read mux
   // ---------------------------------------------------------------
   // decoded in the address phase so the answer leaves a flop with no wait state
   always_comb begin
      hrdata_d = 32'h00000000;
      if (ar_d) begin
         case (haddr_in[7:0])
            FSH_REG_CTRL: hrdata_d = {26'h0000000, ctrl_q};
            FSH_REG_ADDR: hrdata_d = {12'h000, addr_q};
            FSH_REG_WDATA: hrdata_d = {16'h0000, wdata_q};
            FSH_REG_RDATA: hrdata_d = {16'h0000, rdata_q};
            FSH_REG_STAT: hrdata_d = {29'h00000000, valid_q, ready_q, pin.busy};
            default: hrdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         hrdata_q <= 32'h00000000;
      end else begin
         hrdata_q <= hrdata_d;
      end
   end

   // zero-wait slave: every transfer completes in its data phase
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign hrdata_out = hrdata_q;

   // ---------------------------------------------------------------
   // pin engine
   // ---------------------------------------------------------------
   assign pin.start = start_q;
   assign pin.wr = ctrl_q[FSH_CTRL_WRITE];
   assign pin.wide = ctrl_q[FSH_CTRL_WIDE];
   assign pin.addr = addr_q;
   assign pin.wdata = wdata_q;

   fsh_pin_engine u_eng (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .req(pin),
      .dq_in(dq_in),
      .dq_out(dq_out),
      .dq_oe_out(dq_oe_out),
      .addr_out(addr_out),
      .ce_n_out(ce_n_out),
      .oe_n_out(oe_n_out),
      .we_n_out(we_n_out),
      .byte_n_out(byte_n_out)
   );

   // reset pin released high in reset
   assign reset_powerdown_n_out = !ctrl_q[FSH_CTRL_RST];
   assign write_protect_n_out = !ctrl_q[FSH_CTRL_WP];
endmodule // fsh_host_ctrl

//--- src/fsh_pin_engine.sv
// Purpose: runs one strobe cycle on the flash pins
// Assumes: device strobes sampled by the device asynchronously
// Notes: every read opens with a fresh falling edge of chip select and output enable
`timescale 1ns/1ps
module fsh_pin_engine
   import fsh_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   fsh_pin_if.engine req,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe_out,
   output logic [19:0] addr_out,
   output logic ce_n_out,
   output logic oe_n_out,
   output logic we_n_out,
   output logic byte_n_out
);
   typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} fsh_eng_e;
   fsh_eng_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic wr_q, wr_d;
   logic wide_q, wide_d;
   logic [19:0] addr_q, addr_d;
   logic [15:0] wdata_q, wdata_d;
   logic [15:0] rdata_q, rdata_d;
   logic done_q, done_d;

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      wide_d = wide_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      done_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (req.start) begin
               wr_d = req.wr;
               wide_d = req.wide;
               addr_d = req.addr;
               wdata_d = req.wdata;
               st_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            cnt_d = 4'(FSH_ACCESS_CYC);
            st_d = ST_STROBE;
         end
         ST_STROBE: begin
            if (cnt_q <= 4'h1) begin
               if (!wide_q) begin
                  rdata_d = {8'h00, dq_in[7:0]};
               end else begin
                  rdata_d = dq_in;
               end
               st_d = ST_RECOVER;
               cnt_d = 4'(FSH_RECOVER_CYC);
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         ST_RECOVER: begin
            if (cnt_q <= 4'h1) begin
               st_d = ST_IDLE;
               done_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         wr_q <= 1'b0;
         wide_q <= 1'b1;
         addr_q <= 20'h00000;
         wdata_q <= 16'h0000;
         rdata_q <= 16'h0000;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         wide_q <= wide_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
      end
   end

   // ---------------------------------------------------------------
   // pins
   // ---------------------------------------------------------------
   logic active;
   assign active = (st_q == ST_STROBE);
   assign ce_n_out = !(st_q == ST_SETUP || active);
   assign oe_n_out = !(active && !wr_q);
   assign we_n_out = !(active && wr_q);
   assign byte_n_out = wide_q;
   assign addr_out = addr_q;
   always_comb begin
      dq_out = wdata_q;
      dq_oe_out = 16'h0000;
      if (!wide_q) begin
         dq_out = {addr_q[0], 7'h00, wdata_q[7:0]};
         dq_oe_out = 16'h8000;
      end
      if ((st_q == ST_SETUP || active) && wr_q) begin
         dq_oe_out = wide_q ? 16'hFFFF : 16'h80FF;
      end
   end
   assign req.rdata = rdata_q;
   assign req.busy = (st_q != ST_IDLE);
   assign req.done = done_q;
endmodule // fsh_pin_engine

//--- testbench/fsh_flash_model.sv
// Purpose: behavioural flash device facing the host controller
// Assumes: strobes from the host, no clock of its own
// Notes: one status word; busy bank set by top address bit; array word is {addr[8:1], C3h}; reserved bits read 11
`timescale 1ns/1ps
module fsh_flash_model
   import fsh_pkg::*;
#(
   parameter int OP_NS = 8000,
   // identity values are arbitrary
   parameter logic [7:0] MFR_CODE = 8'h5E,
   parameter logic [7:0] DEV_CODE = 8'h71
) (
   input wire logic [15:0] hdq_in,
   input wire logic [15:0] hoe_in,
   input wire logic [19:0] addr_in,
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic byte_n_in,
   input wire logic pd_n_in,
   input wire logic fail_in,
   input wire logic vpp_low_in,
   output logic [15:0] dq_bus_out
);
   logic [7:0] st_q = 8'h83;
   logic [7:0] lat_q = 8'h83;
   logic [7:0] pend_q = 8'h00;
   logic [7:0] op_q = 8'h00;
   logic [1:0] mode_q = 2'd0;
   logic bank_q = 1'b0;
   logic [15:0] drv;
   logic [15:0] flt_q = 16'h5555;
   int gen = 0;
   wire logic rd = !ce_n_in && !oe_n_in && we_n_in && pd_n_in;
   wire logic wr = !ce_n_in && !we_n_in && oe_n_in && pd_n_in;
   wire logic [15:0] en = !rd ? 16'h0000 : byte_n_in ? 16'hFFFF : 16'h00FF;
   task automatic run_op(input int g);
      #(OP_NS);
      if (g == gen && !st_q[7]) st_q[7:4] = {1'b1, st_q[6], fail_in && op_q == 8'h20, fail_in && op_q == 8'h40};
   endtask
   always @(negedge pd_n_in) begin
      st_q = 8'h83;
      mode_q = 2'd0;
      pend_q = 8'h00;
      gen++;
   end
   always @(posedge wr) begin
      if (pend_q != 8'h00) begin
         op_q = pend_q;
         bank_q = addr_in[19];
         pend_q = 8'h00;
         mode_q = 2'd1;
         gen++;
         st_q[3] = vpp_low_in;
         st_q[7] = vpp_low_in;
         if (!vpp_low_in) fork run_op(gen); join_none
      end else if (!st_q[7] && addr_in[19] == bank_q) begin
         // busy takes status and suspend only
         // the other bank falls through to the full set below
         if (dq_bus_out[7:0] == FSH_CMD_READ_STATUS) mode_q = 2'd1;
         if (dq_bus_out[7:0] == FSH_CMD_SUSPEND) begin
            st_q[6] = op_q == 8'h20;
            st_q[2] = op_q == 8'h40;
            st_q[7] = 1'b1;
            mode_q = 2'd1;
         end
      end else case (dq_bus_out[7:0])
         FSH_CMD_READ_ARRAY: mode_q = 2'd0;
         FSH_CMD_READ_STATUS: mode_q = 2'd1;
         8'h90: mode_q = 2'd2;
         8'h50: st_q[5:3] = 3'b000;
         8'h40, 8'h20: pend_q = dq_bus_out[7:0];
         FSH_CMD_RESUME: if (st_q[6] || st_q[2]) begin
            st_q[7:6] = 2'b00;
            st_q[2] = 1'b0;
            gen++;
            fork run_op(gen); join_none
         end
         default: ;
      endcase
   end
   always @(negedge ce_n_in or negedge oe_n_in) if (!ce_n_in && !oe_n_in) lat_q = st_q;
   always_comb begin
      case (mode_q)
         2'd0: drv = byte_n_in ? {addr_in[8:1], 8'hC3} : dq_bus_out[15] ? {8'h00, addr_in[8:1]} : 16'h00C3;
         2'd1: drv = {8'h00, lat_q};
         default: drv = {8'h00, addr_in[0] ? DEV_CODE : MFR_CODE};
      endcase
   end
   always_comb for (int i = 0; i < 16; i++) dq_bus_out[i] = hoe_in[i] ? hdq_in[i] : en[i] ? drv[i] : flt_q[i];
   // floating lines invert, so a stale value never reads as good
   always @* for (int i = 0; i < 16; i++) if (hoe_in[i] || en[i]) flt_q[i] = ~dq_bus_out[i];
endmodule // fsh_flash_model

//--- testbench/fsh_host_ctrl_assertions.sv
// Purpose: pin protocol checks on the flash host controller
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the top module from the bench
`timescale 1ns/1ps
module fsh_host_ctrl_assertions (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [15:0] dq_oe_out,
   input wire logic ce_n_out,
   input wire logic oe_n_out,
   input wire logic we_n_out,
   input wire logic byte_n_out,
   input wire logic reset_powerdown_n_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   property p_no_fight; oe_n_out || we_n_out; endproperty
   a_no_fight: assert property (p_no_fight) else $error("oe and we low together");
   property p_wr_lvl; !we_n_out |-> !ce_n_out && oe_n_out && reset_powerdown_n_out; endproperty
   a_wr_lvl: assert property (p_wr_lvl) else $error("bad write levels");
   property p_rd_float; !oe_n_out |-> dq_oe_out[14:0] == 15'h0000; endproperty
   a_rd_float: assert property (p_rd_float) else $error("host drives during read");
   property p_byte_lines; !byte_n_out |-> dq_oe_out[15] && dq_oe_out[14:8] == 7'h00; endproperty
   a_byte_lines: assert property (p_byte_lines) else $error("byte mode line use");
   property p_word_wr; byte_n_out && !we_n_out |-> dq_oe_out == 16'hFFFF; endproperty
   a_word_wr: assert property (p_word_wr) else $error("word write lines");
   property p_cmd_low; !we_n_out |-> dq_oe_out[7:0] == 8'hFF; endproperty
   a_cmd_low: assert property (p_cmd_low) else $error("command lines not driven");
   property p_rd_cycle;
      $fell(oe_n_out) |-> !$past(ce_n_out) && !oe_n_out ##1 !oe_n_out ##1 oe_n_out && ce_n_out;
   endproperty
   a_rd_cycle: assert property (p_rd_cycle) else $error("read strobe shape");
   property p_wr_cycle;
      $fell(we_n_out) |-> !$past(ce_n_out) && !we_n_out ##1 !we_n_out ##1 we_n_out && ce_n_out;
   endproperty
   a_wr_cycle: assert property (p_wr_cycle) else $error("write strobe shape");
endmodule // fsh_host_ctrl_assertions

//--- testbench/fsh_host_ctrl_tb_top.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: 20 MHz clock, AHB-Lite single word transfers
// Notes: device side is a behavioural model with short operation times
`timescale 1ns/1ps
bind fsh_host_ctrl fsh_host_ctrl_assertions u_chk (.clk_sys_in, .sys_rst_in, .dq_oe_out, .ce_n_out, .oe_n_out,
   .we_n_out, .byte_n_out, .reset_powerdown_n_out);
module fsh_host_ctrl_tb_top;
   import fsh_pkg::*;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [19:0] addr;
      logic [15:0] wd;
      logic [15:0] exp;
   } fsh_row_s;
   localparam fsh_row_s ROWS [9] = '{'{8'h07, 20'h0, 16'h00FF, 16'h0}, '{8'h05, 20'h00246, 16'h0, 16'h23C3},
      '{8'h01, 20'h00012, 16'h0, 16'h00C3}, '{8'h01, 20'h00013, 16'h0, 16'h0009}, '{8'h07, 20'h0, 16'h0090, 16'h0},
      '{8'h05, 20'h0, 16'h0, 16'h005E}, '{8'h05, 20'h1, 16'h0, 16'h0071}, '{8'h07, 20'h0, 16'h0070, 16'h0},
      '{8'h0D, 20'h0, 16'h0, 16'h0080}};
   localparam logic [7:0] FIN [4] = '{8'h80, 8'h90, 8'hA0, 8'h88};
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic fail = 1'b0;
   logic vpp_low = 1'b0;
   logic [31:0] hrdata, v, s;
   logic hready, hresp, ce_n, oe_n, we_n, byte_n, pd_n, wp_n;
   logic [15:0] dq_bus, dq_out, dq_oe;
   logic [19:0] addr;
   int n_fail = 0;
   int n_checks = 0;
   always #25 clk_sys_in = ~clk_sys_in;
   fsh_host_ctrl dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .dq_in(dq_bus), .dq_out(dq_out),
      .dq_oe_out(dq_oe), .addr_out(addr), .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n),
      .byte_n_out(byte_n), .reset_powerdown_n_out(pd_n), .write_protect_n_out(wp_n));
   fsh_flash_model u_flash (.hdq_in(dq_out), .hoe_in(dq_oe), .addr_in(addr), .ce_n_in(ce_n), .oe_n_in(oe_n),
      .we_n_in(we_n), .byte_n_in(byte_n), .pd_n_in(pd_n), .fail_in(fail), .vpp_low_in(vpp_low),
      .dq_bus_out(dq_bus));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge clk_sys_in); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk_sys_in); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic pin(input logic [7:0] c, input logic [19:0] a, input logic [15:0] d, output logic [31:0] r);
      bus(1'b1, FSH_REG_ADDR, {12'h000, a}, r);
      bus(1'b1, FSH_REG_WDATA, {16'h0000, d}, r);
      bus(1'b1, FSH_REG_CTRL, {24'h000000, c}, r);
      repeat (2) @(posedge clk_sys_in);
      r = 32'h1;
      while (r[FSH_STAT_BUSY] !== 1'b0) bus(1'b0, FSH_REG_STAT, 32'h0, r);
      bus(1'b0, FSH_REG_RDATA, 32'h0, r);
   endtask
   task automatic poll();
      pin(8'h0D, 20'h0, 16'h0, v);
      bus(1'b0, FSH_REG_STAT, 32'h0, s);
   endtask
   task automatic cmd(input logic [15:0] d);
      pin(8'h07, 20'h0, d, s);
   endtask
   task automatic wait_ready();
      for (int n = 0; n < 40 && v[7] !== 1'b1; n++) poll();
   endtask
   task automatic op(input logic [15:0] c1, input logic [15:0] c2, input logic [7:0] fin);
      cmd(c1);
      cmd(c2);
      poll();
      check(v, vpp_low ? {24'h0, fin} : 32'h0);
      check(s & 32'h7, vpp_low ? 32'h6 : 32'h0);
      wait_ready();
      check(v, {24'h0, fin});
      check(s & 32'h7, 32'h6);
      cmd(16'h0050);
   endtask
   initial begin
      repeat (3) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      bus(1'b0, FSH_REG_CTRL, 32'h0, v);
      check(v, 32'h4);
      check({29'h0, hresp, wp_n, byte_n}, 32'h3);
      bus(1'b1, 8'h20, 32'hFFFFFFFF, v);
      bus(1'b0, 8'h20, 32'h0, v);
      check(v, 32'h0);
      // go with the reset pin held low must be refused
      bus(1'b1, FSH_REG_CTRL, 32'h35, v);
      @(negedge clk_sys_in);
      check({30'h0, pd_n, wp_n}, 32'h0);
      repeat (2) @(posedge clk_sys_in);
      bus(1'b0, FSH_REG_STAT, 32'h0, v);
      check(v, 32'h0);
      foreach (ROWS[i]) begin
         pin(ROWS[i].ctrl, ROWS[i].addr, ROWS[i].wd, v);
         if (!ROWS[i].ctrl[1]) check(v, {16'h0, ROWS[i].exp});
      end
      for (int i = 0; i < 4; i++) begin
         fail <= i == 1 || i == 2;
         vpp_low <= i == 3;
         op(i == 2 ? 16'h0020 : 16'h0040, i == 2 ? 16'h00D0 : 16'h1234, FIN[i]);
      end
      fail <= 1'b0;
      vpp_low <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         cmd(i ? 16'h0020 : 16'h0040);
         cmd(i ? 16'h00D0 : 16'h1234);
         cmd(16'h0090);
         poll();
         check(v, 32'h0);
         pin(8'h07, 20'h80000, 16'h0090, s);
         pin(8'h05, 20'h80000, 16'h0, v);
         check(v, 32'h5E);
         cmd(16'h00B0);
         poll();
         check(v, i ? 32'hC0 : 32'h84);
         cmd(16'h0070);
         poll();
         check(v, i ? 32'hC0 : 32'h84);
         cmd(16'h00D0);
         poll();
         check(v, 32'h0);
         wait_ready();
         check(v, 32'h80);
      end
      sys_rst_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      bus(1'b0, FSH_REG_CTRL, 32'h0, v);
      check(v, 32'h4);
      bus(1'b0, FSH_REG_STAT, 32'h0, v);
      check(v, 32'h0);
      bus(1'b0, FSH_REG_RDATA, 32'h0, v);
      check(v, 32'h0);
      finish_test();
   end
   // whole run is near 1550 cycles; this leaves ample margin
   initial begin
      #400000;
      n_fail++;
      finish_test();
   end
endmodule // fsh_host_ctrl_tb_top
